/* File: include/rsl_pkg.sv */
// package for the registered sum-of-products logic array
// Behaviour
// - product terms formed in programmable and-array, summed by fixed or-array per output
// - once power-up is done, each rising clock edge loads every registered flip-flop with its or sum
// - registered flip-flop values feed back into the and-array as input terms
// - power-up clears all flip-flops low, complete within 1000 ns, no reset pin
// - registered pins drive through inverting buffer, so cleared flop reads high
// - with security fuse programmed, pattern readback is refused
`default_nettype none
package rsl_pkg;
  localparam int unsigned DED_INPUTS      = 8;
  localparam int unsigned REG_OUTPUTS     = 4;
  localparam int unsigned COMB_OUTPUTS    = 4;
  localparam int unsigned TERMS_PER_OUT   = 8;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned POR_TIME_NS     = 1000;
  // longest time: round down
  localparam int unsigned POR_CYCLES      = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned POR_CNT_W       = $clog2(POR_CYCLES + 1);
  // array inputs: dedicated pins, register feedback, combinatorial pin feedback
  localparam int unsigned ARRAY_INPUTS    = DED_INPUTS + REG_OUTPUTS + COMB_OUTPUTS;
  localparam int unsigned COLS            = 2 * ARRAY_INPUTS;
  localparam int unsigned REG_TERMS       = REG_OUTPUTS * TERMS_PER_OUT;
  // comb output uses one term for enable plus the remaining for the sum
  localparam int unsigned COMB_TERMS      = COMB_OUTPUTS * TERMS_PER_OUT;
  localparam int unsigned ALL_TERMS       = REG_TERMS + COMB_TERMS;
  localparam int unsigned FUSE_BITS       = ALL_TERMS * COLS;
  localparam int unsigned FUSE_ADDR_W     = $clog2(ALL_TERMS);

  typedef struct packed {
    logic [POR_CNT_W-1:0]   por_cnt;
    logic                   por_done;
    logic [REG_OUTPUTS-1:0] q;
    logic [COLS-1:0]        rd_row;
  } rsl_state_type;

  typedef struct packed {
    logic [REG_OUTPUTS-1:0]  reg_o;
    logic [REG_OUTPUTS-1:0]  reg_oe;
    logic [COMB_OUTPUTS-1:0] comb_o;
    logic [COMB_OUTPUTS-1:0] comb_oe;
  } rsl_pins_type;
endpackage : rsl_pkg
`default_nettype wire

/* File: sim/rsl_chk.sv */
// port assertions for rsl_array
`timescale 1ns/1ps
`default_nettype none
module rsl_chk import rsl_pkg::*; (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        oe_n_i,
  input wire logic        secure_i,
  input wire rsl_pins_type pins_o,
  input wire logic [COLS-1:0] rd_data_o,
  input wire logic        ready_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_oe_on: assert property (!oe_n_i |-> pins_o.reg_oe == '1) else $error("oe");
  chk_oe_off: assert property (oe_n_i |-> pins_o.reg_oe == '0) else $error("oe");
  chk_oe_change: assert property ($changed(oe_n_i) |-> $changed(pins_o.reg_oe)) else $error("oe");
  chk_por_high: assert property (!ready_o |-> pins_o.reg_o == '1) else $error("por");
  chk_ready_hold: assert property (ready_o |=> ready_o) else $error("rdy");
  chk_clear_high: assert property ($rose(ready_o) |-> pins_o.reg_o == '1) else $error("clr");
  chk_load_only: assert property ($changed(pins_o.reg_o) |-> $past(ready_o)) else $error("ld");
  chk_secure_zero: assert property (secure_i |=> rd_data_o == '0) else $error("sec");
  cover property ($rose(ready_o));
  cover property ($changed(pins_o.reg_o));
  cover property (secure_i ##1 secure_i);
endmodule : rsl_chk
bind rsl_array rsl_chk rsl_chk_inst (.*);
`default_nettype wire

/* File: sim/tb.sv */
// bench for rsl_array
`timescale 1ns/1ps
`default_nettype none
module tb import rsl_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, oe_n = 1'b0, sec = 1'b0, rdy;
  logic [COLS-1:0] rdd;
  logic [FUSE_BITS-1:0] fm = '1;
  logic [FUSE_ADDR_W-1:0] row = 6'h0;
  rsl_pins_type pins;
  int fail_count = 0, n_checks = 0;
  rsl_array #(.POR_CYC(4)) rsl_array_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .din_i(8'h0), .oe_n_i(oe_n),
    .comb_pin_i(4'h0), .fuse_map_i(fm), .secure_i(sec), .rd_row_i(row), .pins_o(pins), .rd_data_o(rdd), .ready_o(rdy));
  initial forever #4 clk = ~clk;
  task automatic cmp(logic [31:0] got, exp);
    n_checks++;
    fail_count += int'(got !== exp);
    if (got !== exp) $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
  endtask : cmp
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic power_up;
    int n = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    while (rdy !== 1'b1 && n < 50) @(posedge clk) #1 n++;
    cmp(n, 4);
    cmp(pins.reg_o, 4'hf);
  endtask : power_up
  task automatic toggle_run;
    for (int k = 1; k <= 4; k++)
      @(posedge clk) #1 cmp(pins.reg_o, k[0] ? 4'h0 : 4'hf);
  endtask : toggle_run
  task automatic output_paths;
    cmp({pins.comb_oe, pins.comb_o}, 8'h1f);
    @(posedge clk);
    row <= 6'h8;
    oe_n <= 1'b1;
    @(posedge clk);
    sec <= 1'b1;
    #1 cmp(rdd, 32'h80000);
    cmp(pins.reg_oe, 4'h0);
    repeat (2) @(posedge clk) #1 cmp(rdd, 32'h0);
  endtask : output_paths
  initial begin
    // each flop's first term keeps only its own inverted feedback, so it toggles
    for (int o = 0; o < 4; o++) fm[o*256 +: 32] = 32'h1 << (17 + 2*o);
    fm[1024 +: 32] = 32'h0;
    power_up();
    toggle_run();
    output_paths();
    // second power-up in mid-run: flops must clear again and outputs read high
    rst_n <= 1'b0;
    #1 cmp(pins.reg_o, 4'hf);
    power_up();
    complete_run();
  end
endmodule : tb
`default_nettype wire

/* File: src/rsl_array.sv */
// registered sum-of-products logic array top
`timescale 1ns/1ps
`default_nettype none
module rsl_array
  import rsl_pkg::*;
#(
  parameter int unsigned POR_CYC = POR_CYCLES
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [DED_INPUTS-1:0]   din_i,
  input  wire logic                    oe_n_i,
  input  wire logic [COMB_OUTPUTS-1:0] comb_pin_i,
  input  wire logic [FUSE_BITS-1:0]    fuse_map_i,
  input  wire logic                    secure_i,
  input  wire logic [FUSE_ADDR_W-1:0]  rd_row_i,
  output rsl_pins_type                 pins_o,
  output logic [COLS-1:0]              rd_data_o,
  output logic                         ready_o
);
  rsl_state_type              state_reg;
  rsl_state_type              state_next;
  logic [ARRAY_INPUTS-1:0]    arr_in;
  logic [ALL_TERMS-1:0]       terms;
  logic [COMB_OUTPUTS-1:0]    comb_en;
  logic [COMB_OUTPUTS-1:0]    comb_sum;
  logic [REG_OUTPUTS-1:0]     reg_sum;

  function automatic logic or_terms(input logic [TERMS_PER_OUT-1:0] t, input int unsigned first);
    logic r;
    r = 1'b0;
    for (int k = 0; k < TERMS_PER_OUT; k++)
      if (k >= first)
        r = r | t[k];
    return r;
  endfunction : or_terms

  // feedback is the flop value itself; comb pins always read back pin level from comb_pin_i, never own drive
  always_comb begin
    arr_in = {comb_pin_i, state_reg.q, din_i};
  end

  for (genvar t = 0; t < ALL_TERMS; t++) begin : g_term
    rsl_term #(.N(ARRAY_INPUTS)) u_term (
      .in_i   (arr_in),
      .keep_i (fuse_map_i[t*COLS +: COLS]),
      .term_o (terms[t])
    );
  end

  always_comb begin
    for (int o = 0; o < REG_OUTPUTS; o++)
      reg_sum[o] = or_terms(terms[o*TERMS_PER_OUT +: TERMS_PER_OUT], 0);
    for (int o = 0; o < COMB_OUTPUTS; o++) begin
      comb_en[o]  = terms[REG_TERMS + o*TERMS_PER_OUT];
      // active-low sum, as on and-or-invert outputs
      comb_sum[o] = ~or_terms(terms[REG_TERMS + o*TERMS_PER_OUT +: TERMS_PER_OUT], 1);
    end
  end

  always_comb begin
    state_next = state_reg;
    if (!state_reg.por_done) begin
      // flops held low until the power-up window has run out
      state_next.q = '0;
      if (state_reg.por_cnt == POR_CNT_W'(POR_CYC - 1))
        state_next.por_done = 1'b1;
      else
        state_next.por_cnt = state_reg.por_cnt + POR_CNT_W'(1);
    end else begin
      state_next.q = reg_sum;
    end
    // a secured part returns all zero so the pattern cannot be copied
    if (secure_i)
      state_next.rd_row = '0;
    else
      state_next.rd_row = fuse_map_i[rd_row_i*COLS +: COLS];
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  always_comb begin
    pins_o.reg_o   = ~state_reg.q;
    pins_o.reg_oe  = {REG_OUTPUTS{~oe_n_i}};
    pins_o.comb_o  = comb_sum;
    pins_o.comb_oe = comb_en;
  end

  assign rd_data_o = state_reg.rd_row;
  // outside party must wait for this before counting on clocked results
  assign ready_o   = state_reg.por_done;
endmodule : rsl_array
`default_nettype wire

/* File: src/rsl_term.sv */
// one product term of the programmable and-array
`timescale 1ns/1ps
`default_nettype none
module rsl_term
  import rsl_pkg::*;
#(
  parameter int unsigned N = ARRAY_INPUTS
) (
  input  wire logic [N-1:0]   in_i,
  input  wire logic [2*N-1:0] keep_i,
  output logic                term_o
);
  // a kept cell connects the true (even) or complement (odd) column; all intact makes term low
  always_comb begin
    term_o = 1'b1;
    for (int k = 0; k < N; k++) begin
      if (keep_i[2*k] && !in_i[k])
        term_o = 1'b0;
      if (keep_i[2*k+1] && in_i[k])
        term_o = 1'b0;
    end
  end
endmodule : rsl_term
`default_nettype wire
